// ===== sdram_init_self_refresh_seq_tb_top.sv
// sdram_init_self_refresh_seq_tb_top: self-checking bench for sdsq_ctrl
// assumes shortened power-up and burst counts; inputs change on falling edges
`timescale 1ns/1ps
module sdram_init_self_refresh_seq_tb_top;
   import sdsq_pkg::*;
   localparam int PU_US = 2;
   localparam int BREF  = 4;
   logic        i_mclk = 1'b0, i_rst, i_sr_enter, i_sr_exit, i_burst_mode, i_acc_req;
   logic [3:0]  i_acc_cmd;
   logic [12:0] i_acc_addr, o_addr;
   logic [1:0]  i_acc_bank, o_ba, o_dqm;
   logic        o_acc_ack, o_init_done, o_in_self_refresh, o_ready, o_clk_en, o_cke;
   logic        o_cs_n, o_ras_n, o_cas_n, o_we_n, m_pre_all, m_mode_ok, m_in_sr;
   logic [15:0] m_ref_cnt, m_acc_cnt;
   logic [7:0]  m_err;
   int          num_errors = 0, total_checks = 0, exp_ref = 2, exp_acc = 0, ack_seen = 0;
   int          exp_dev = 0;
   sdsq_cmd_t   cmds [4] = '{SDSQ_CMD_ACTIVATE, SDSQ_CMD_WRITE, SDSQ_CMD_READ, SDSQ_CMD_PRECHARGE};
   always #2.5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (o_acc_ack === 1'b1) ack_seen++;
   sdsq_ctrl #(.POWERUP_US(PU_US), .BURST_REF(BREF)) u_dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_sr_enter(i_sr_enter), .i_sr_exit(i_sr_exit),
      .i_burst_mode(i_burst_mode), .i_acc_req(i_acc_req), .i_acc_cmd(i_acc_cmd),
      .i_acc_addr(i_acc_addr), .i_acc_bank(i_acc_bank), .o_acc_ack(o_acc_ack),
      .o_init_done(o_init_done), .o_in_self_refresh(o_in_self_refresh), .o_ready(o_ready),
      .o_clk_en(o_clk_en), .o_cke(o_cke), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n),
      .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_addr(o_addr), .o_dqm(o_dqm));
   sdsq_dev_model u_mem (
      .i_mclk(i_mclk), .i_clk_en(o_clk_en), .i_cke(o_cke), .i_cs_n(o_cs_n),
      .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_addr(o_addr),
      .o_pre_all(m_pre_all), .o_mode_ok(m_mode_ok), .o_in_sr(m_in_sr),
      .o_ref_cnt(m_ref_cnt), .o_acc_cnt(m_acc_cnt), .o_err(m_err));
   ////////////////////////////////////////////////////////////////////////////////
   // comparison, bounded wait and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      repeat (lim) begin
         if (sig === lvl) return;
         @(negedge i_mclk);
      end
      check(sig, lvl, "wait limit");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one user command, held until its ack
   task automatic access(input logic [3:0] cmd);
      logic [12:0] a;
      logic [1:0]  b;
      a = 13'($urandom);
      b = 2'($urandom);
      {i_acc_cmd, i_acc_addr, i_acc_bank, i_acc_req} = {cmd, a, b, 1'b1};
      @(negedge i_mclk);
      wait_for(o_acc_ack, 1'b1, 20);
      i_acc_req = 1'b0;
      check({o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_addr}, {cmd, b, a}, "pins");
      exp_acc++;
      if (cmd inside {SDSQ_CMD_ACTIVATE, SDSQ_CMD_READ, SDSQ_CMD_WRITE})
         exp_dev++;
      @(negedge i_mclk);
   endtask
   // self-refresh round trip with a refused request inside
   task automatic self_refresh(input logic burst);
      {i_burst_mode, i_sr_enter} = {burst, 1'b1};
      wait_for(o_in_self_refresh, 1'b1, 300);
      i_sr_enter = 1'b0;
      wait_for(o_clk_en, 1'b0, 50);
      check(m_in_sr, 1'b1, "device in self-refresh");
      {i_acc_cmd, i_acc_req} = {SDSQ_CMD_READ, 1'b1};
      repeat ($urandom_range(20, 3)) @(negedge i_mclk);
      check(o_cke, 1'b0, "gate held low");
      i_acc_req = 1'b0;
      @(negedge i_mclk);
      i_sr_exit = 1'b1;
      wait_for(o_in_self_refresh, 1'b0, 100);
      i_sr_exit = 1'b0;
      wait_for(o_ready, 1'b1, 300);
      if (burst) exp_ref += 2 * BREF;
      check(m_ref_cnt, exp_ref, "refresh count");
      check(m_err, 0, "device protocol");
      check(ack_seen, exp_acc, "refused request");
      $display("test self-refresh burst=%0d done", burst);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {i_rst, i_sr_enter, i_sr_exit, i_burst_mode, i_acc_req} = 5'h10;
      {i_acc_cmd, i_acc_addr, i_acc_bank} = '0;
      void'($urandom(32'h5afd_3c48));
      repeat (8) @(negedge i_mclk);
      check({o_cke, o_dqm, o_cs_n, o_ras_n, o_cas_n, o_we_n}, 7'h37, "power-up pins");
      i_rst = 1'b0;
      {i_acc_cmd, i_acc_req} = {SDSQ_CMD_ACTIVATE, 1'b1};
      repeat (PU_US * CLK_MHZ - 50) @(negedge i_mclk);
      check(o_cke, 1'b0, "gate low in wait");
      i_acc_req = 1'b0;
      wait_for(o_init_done, 1'b1, 400);
      check(ack_seen, 0, "early request");
      check({m_pre_all, m_mode_ok}, 2'h3, "init steps");
      check(m_ref_cnt, exp_ref, "init refreshes");
      $display("test init done");
      foreach (cmds[i]) access(cmds[i]);
      check(m_acc_cnt, exp_dev, "device accesses");
      $display("test access done");
      self_refresh(1'b0);
      self_refresh(1'b1);
      final_report;
   end
   // watchdog against a hung sequence
   initial begin
      #20us;
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report;
   end
endmodule

// ===== sdsq_ctrl.sv
// sdsq_ctrl: drives an sdr sdram through power-up init and self-refresh
// assumes inputs synchronous to i_mclk; the memory clock is gated by o_clk_en
// the memory clock stops only while self-refresh is being held
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - power-up: gate low, mask high, nop
// - 200 us stable clock before gate high
// - keep mask high while gate rises
// - precharge all banks during init
// - load mode register before any access
// - at least two init auto-refreshes
// - refreshes before or after mode set
// - enter: cs, ras, cas low, gate low
// - hold self-refresh at least row-active time
// - restart clock, settle, then raise gate
// - chip select high as gate rises
// - wait exit delay before any command
// - 8192 burst refreshes around self-refresh
// - exit delay is row cycle plus setup
// - row-active time at least 40 ns
module sdsq_ctrl
   import sdsq_pkg::*;
#(
   parameter int POWERUP_US = T_POWERUP_US,
   parameter int BURST_REF  = BURST_REFRESH_CNT
)
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_sr_enter,
   input  wire logic        i_sr_exit,
   input  wire logic        i_burst_mode,
   input  wire logic        i_acc_req,
   input  wire logic [3:0]  i_acc_cmd,
   input  wire logic [12:0] i_acc_addr,
   input  wire logic [1:0]  i_acc_bank,
   output logic             o_acc_ack,
   output logic             o_init_done,
   output logic             o_in_self_refresh,
   output logic             o_ready,
   output logic             o_clk_en,
   output logic             o_cke,
   output logic             o_cs_n,
   output logic             o_ras_n,
   output logic             o_cas_n,
   output logic             o_we_n,
   output logic [1:0]       o_ba,
   output logic [12:0]      o_addr,
   output logic [1:0]       o_dqm
);
   typedef enum logic [3:0] {
      S_POWERUP, S_PRECHARGE, S_TRP, S_REFRESH, S_TRFC, S_MODE, S_TMRD,
      S_IDLE, S_PRE_BURST, S_SR_HOLD, S_CLK_SETTLE, S_XSR, S_POST_BURST
   } sdsq_state_t;

   // whole sequencer state: one comb copy, one register
   // ref_cnt serves the init pair and both refresh bursts
   typedef struct packed {
      sdsq_state_t st;
      logic [15:0] us_cnt;
      logic [13:0] ref_cnt;
      logic        init_done;
      logic        in_sr;
      logic        ready;
      logic        ack;
      logic        clk_en;
      logic        cke;
      logic [3:0]  cmd;
      logic [1:0]  ba;
      logic [12:0] addr;
      logic [1:0]  dqm;
      logic        dly_load;
      logic [CNT_W-1:0] dly_val;
   } sdsq_ctl_t;

   sdsq_ctl_t s, next_s;
   logic us_tick;
   logic dly_busy;
   logic dly_done;

   // decode of the commands the user may not issue before init
   function automatic logic is_access(input logic [3:0] c);
      return (c == SDSQ_CMD_READ) || (c == SDSQ_CMD_WRITE) || (c == SDSQ_CMD_ACTIVATE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // 1 us ticks for the power-up wait
   sdsq_divider u_div (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .o_tick (us_tick)
   );

   // one shared down-counter times every least wait
   sdsq_delay u_dly (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_load  (s.dly_load),
      .i_count (s.dly_val),
      .o_busy  (dly_busy),
      .o_done  (dly_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_s          = s;
      next_s.cmd      = no_operation_command;
      next_s.ack      = 1'b0;
      next_s.dly_load = 1'b0;
      next_s.addr     = 13'h0_000;
      next_s.ba       = 2'h0;
      case (s.st)
         S_POWERUP: begin
            // us_cnt advances on each 1 us divider tick
            next_s.cke = 1'b0;
            next_s.dqm = 2'h3;
            if (us_tick)
               next_s.us_cnt = s.us_cnt + 16'h0001;
            if (s.us_cnt >= 16'(POWERUP_US)) begin
               next_s.cke = 1'b1;
               next_s.st  = S_PRECHARGE;
            end
         end
         S_PRECHARGE: begin
            next_s.cmd                 = SDSQ_CMD_PRECHARGE;
            next_s.addr[A_ALLBANK_BIT] = 1'b1;
            next_s.dly_load            = 1'b1;
            next_s.dly_val             = CNT_W'(RP_CYC);
            next_s.st                  = S_TRP;
         end
         S_TRP: begin
            if (dly_done) begin
               next_s.ref_cnt = 14'h0000;
               next_s.st      = S_REFRESH;
            end
         end
         S_REFRESH: begin
            next_s.cmd      = SDSQ_CMD_REFRESH;
            next_s.ref_cnt  = s.ref_cnt + 14'h0001;
            next_s.dly_load = 1'b1;
            next_s.dly_val  = CNT_W'(RFC_CYC);
            next_s.st       = S_TRFC;
         end
         S_TRFC: begin
            if (dly_done) begin
               if (!s.init_done && s.ref_cnt < 14'(INIT_REFRESH_CNT))
                  next_s.st = S_REFRESH;
               else if (!s.init_done)
                  next_s.st = S_MODE;
               else
                  next_s.st = S_IDLE;
            end
         end
         S_MODE: begin
            next_s.cmd      = SDSQ_CMD_MODE_SET;
            next_s.addr     = MODE_RESET;
            next_s.dly_load = 1'b1;
            next_s.dly_val  = CNT_W'(MRD_CYC);
            next_s.st       = S_TMRD;
         end
         S_TMRD: begin
            if (dly_done) begin
               next_s.init_done = 1'b1;
               next_s.dqm       = 2'h0;
               next_s.st        = S_IDLE;
            end
         end
         S_IDLE: begin
            // entry wins over a user command in the same cycle
            if (i_sr_enter) begin
               next_s.ref_cnt = 14'h0000;
               next_s.st      = S_PRE_BURST;
            end else if (i_acc_req) begin
               next_s.cmd  = i_acc_cmd;
               next_s.addr = i_acc_addr;
               next_s.ba   = i_acc_bank;
               next_s.ack  = 1'b1;
            end
         end
         // the delay's busy flag rises one cycle after its load,
         // so the registered load bit guards that gap
         // burst refresh before entry
         S_PRE_BURST: begin
            if (i_burst_mode && s.ref_cnt < 14'(BURST_REF)) begin
               if (!dly_busy && !s.dly_load) begin
                  next_s.cmd      = SDSQ_CMD_REFRESH;
                  next_s.ref_cnt  = s.ref_cnt + 14'h0001;
                  next_s.dly_load = 1'b1;
                  next_s.dly_val  = CNT_W'(RFC_CYC);
               end
            end else if (!dly_busy && !s.dly_load) begin
               next_s.cmd      = SDSQ_CMD_REFRESH;
               next_s.cke      = 1'b0;
               next_s.in_sr    = 1'b1;
               next_s.dly_load = 1'b1;
               next_s.dly_val  = CNT_W'(RAS_CYC);
               next_s.st       = S_SR_HOLD;
            end
         end
         S_SR_HOLD: begin
            if (!dly_busy && !s.dly_load) begin
               // clock stops only after the least hold time
               next_s.clk_en = 1'b0;
               if (i_sr_exit) begin
                  next_s.clk_en   = 1'b1;
                  next_s.dly_load = 1'b1;
                  next_s.dly_val  = CNT_W'(CLK_SETTLE_CYC);
                  next_s.st       = S_CLK_SETTLE;
               end
            end
         end
         S_CLK_SETTLE: begin
            if (dly_done) begin
               next_s.cmd      = SDSQ_CMD_DESELECT;
               next_s.cke      = 1'b1;
               next_s.dly_load = 1'b1;
               next_s.dly_val  = CNT_W'(XSR_CYC);
               next_s.st       = S_XSR;
            end else begin
               // deselect while the restarted clock settles
               next_s.cmd = SDSQ_CMD_DESELECT;
            end
         end
         S_XSR: begin
            // deselect holds the device quiet for the exit delay
            next_s.cmd = SDSQ_CMD_DESELECT;
            if (dly_done) begin
               next_s.in_sr   = 1'b0;
               next_s.ref_cnt = 14'h0000;
               next_s.st      = S_POST_BURST;
            end
         end
         S_POST_BURST: begin
            if (i_burst_mode && s.ref_cnt < 14'(BURST_REF)) begin
               if (!dly_busy && !s.dly_load) begin
                  next_s.cmd      = SDSQ_CMD_REFRESH;
                  next_s.ref_cnt  = s.ref_cnt + 14'h0001;
                  next_s.dly_load = 1'b1;
                  next_s.dly_val  = CNT_W'(RFC_CYC);
               end
            end else if (!dly_busy && !s.dly_load) begin
               next_s.st = S_IDLE;
            end
         end
         default: next_s.st = S_POWERUP;
      endcase
      // refuse access commands while init is not done
      // last guard: no user access reaches the pins before init
      if (!s.init_done && is_access(next_s.cmd))
         next_s.cmd = no_operation_command;
      // ready registered so the output comes straight from a flop
      next_s.ready = next_s.init_done && (next_s.st == S_IDLE);
   end

   // state register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         s         <= '0;
         s.st      <= S_POWERUP;
         s.clk_en  <= 1'b1;
         s.cmd     <= no_operation_command;
         s.dqm     <= 2'h3;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state flops
   assign o_acc_ack         = s.ack;
   assign o_init_done       = s.init_done;
   assign o_in_self_refresh = s.in_sr;
   assign o_ready           = s.ready;
   assign o_clk_en          = s.clk_en;
   assign o_cke             = s.cke;
   assign o_cs_n            = s.cmd[3];
   assign o_ras_n           = s.cmd[2];
   assign o_cas_n           = s.cmd[1];
   assign o_we_n            = s.cmd[0];
   assign o_ba              = s.ba;
   assign o_addr            = s.addr;
   assign o_dqm             = s.dqm;
endmodule

// ===== sdsq_ctrl_props.sv
// sdsq_ctrl_props: concurrent checks on the sequencer's memory-side pins and its request/ack handshake
// assumes it is bound to sdsq_ctrl and sees only that module's ports
`timescale 1ns/1ps
module sdsq_ctrl_props
   import sdsq_pkg::*;
#(
   parameter int POWERUP_US = T_POWERUP_US
)
(
   input wire logic       i_mclk,
   input wire logic       i_rst,
   input wire logic       i_acc_req,
   input wire logic       o_acc_ack,
   input wire logic       o_init_done,
   input wire logic       o_in_self_refresh,
   input wire logic       o_clk_en,
   input wire logic       o_cke,
   input wire logic       o_cs_n,
   input wire logic       o_ras_n,
   input wire logic       o_cas_n,
   input wire logic       o_we_n,
   input wire logic [1:0] o_dqm
);
   logic [3:0] cmd;
   logic       quiet;
   int         up_cnt;
   // pin command and "nothing issued" flag
   assign cmd   = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
   assign quiet = o_cs_n | (o_ras_n & o_cas_n & o_we_n);
   // cycles since reset release, frozen once init is done
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         up_cnt <= 0;
      end else if (!o_init_done && up_cnt < 1000000) begin
         up_cnt <= up_cnt + 1;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // self-refresh exit steps
   sequence s_exit_start;
      $rose(o_cke) && o_in_self_refresh;
   endsequence
   sequence s_exit_quiet;
      quiet [*6] ##1 quiet [*6];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_reset_pins_idle: assert property (disable iff (1'b0)
      i_rst |=> !o_cke && o_dqm == 2'h3 && cmd == 4'h7) else $error("pins not idle in reset");
   a_powerup_wait_len: assert property (
      $rose(o_cke) && !o_in_self_refresh |-> up_cnt >= POWERUP_US * CLK_MHZ)
      else $error("gate raised before power-up wait");
   a_gate_rise_mask: assert property (
      $rose(o_cke) && !o_in_self_refresh |-> o_dqm == 2'h3) else $error("mask low at gate rise");
   a_sr_entry_cmd: assert property (
      $fell(o_cke) |-> cmd == SDSQ_CMD_REFRESH) else $error("gate fell without refresh command");
   a_sr_hold_min: assert property (
      $fell(o_cke) |-> !o_cke [*8]) else $error("self-refresh left too early");
   a_exit_clock_settled: assert property (
      s_exit_start |-> $past(o_clk_en, 2) && $past(o_clk_en) && o_cs_n)
      else $error("gate rose on unsettled clock or selected device");
   a_exit_delay_quiet: assert property (
      s_exit_start |-> s_exit_quiet) else $error("command inside exit delay");
   a_no_early_access: assert property (
      !o_init_done && !o_cs_n |-> !({o_ras_n, o_cas_n, o_we_n} inside {3'h3, 3'h5, 3'h4}))
      else $error("access command before init done");
   a_ack_after_request: assert property (
      o_acc_ack |-> o_init_done && $past(i_acc_req)) else $error("ack without request or init");
endmodule
bind sdsq_ctrl sdsq_ctrl_props #(.POWERUP_US(POWERUP_US)) u_props (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_acc_req(i_acc_req), .o_acc_ack(o_acc_ack),
   .o_init_done(o_init_done), .o_in_self_refresh(o_in_self_refresh), .o_clk_en(o_clk_en),
   .o_cke(o_cke), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
   .o_dqm(o_dqm));

// ===== sdsq_delay.sv
// sdsq_delay: loadable down-counter giving a one-cycle done pulse
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module sdsq_delay
   import sdsq_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_count,
   output logic                  o_busy,
   output logic                  o_done
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             busy;
      logic             done;
   } sdsq_dly_t;
   sdsq_dly_t st, next_st;
   // load, count down, pulse at zero
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (i_load) begin
         next_st.cnt  = i_count;
         next_st.busy = (i_count != CNT_ZERO);
         next_st.done = (i_count == CNT_ZERO);
      end else if (st.busy) begin
         if (st.cnt <= 16'h0001) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.cnt  = CNT_ZERO;
         end else begin
            next_st.cnt = st.cnt - 16'h0001;
         end
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst)
         st <= '0;
      else
         st <= next_st;
   end
   assign o_busy = st.busy;
   assign o_done = st.done;
endmodule

// ===== sdsq_dev_model.sv
// sdsq_dev_model: behavioural sdram seen from its command pins
// assumes pins change just after i_mclk rises; i_clk_en gates the memory clock
`timescale 1ns/1ps
module sdsq_dev_model
   import sdsq_pkg::*;
(
   input wire logic        i_mclk,
   input wire logic        i_clk_en,
   input wire logic        i_cke,
   input wire logic        i_cs_n,
   input wire logic        i_ras_n,
   input wire logic        i_cas_n,
   input wire logic        i_we_n,
   input wire logic [12:0] i_addr,
   output logic            o_pre_all,
   output logic            o_mode_ok,
   output logic            o_in_sr,
   output logic [15:0]     o_ref_cnt,
   output logic [15:0]     o_acc_cnt,
   output logic [7:0]      o_err
);
   logic [3:0] cmd;
   logic       cke_q = 1'b0;
   int         xsr = 0;
   assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
   initial begin
      {o_pre_all, o_mode_ok, o_in_sr} = 3'h0;
      {o_ref_cnt, o_acc_cnt, o_err} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // command decode, gated by the previous gate level
   always @(posedge i_mclk) begin
      if (o_in_sr) begin
         if (i_cke) begin
            if (!i_clk_en) o_err <= o_err + 8'h01;
            o_in_sr <= 1'b0;
            xsr <= XSR_CYC - 1;
         end
      end else if (cke_q && i_clk_en) begin
         if (xsr > 0) xsr <= xsr - 1;
         if (xsr > 0 && !i_cs_n && cmd != no_operation_command) o_err <= o_err + 8'h01;
         if (!i_cke) begin
            if (cmd == SDSQ_CMD_REFRESH) o_in_sr <= 1'b1;
            else o_err <= o_err + 8'h01;
         end else begin
            // refresh and mode set in either order
            case (cmd)
               SDSQ_CMD_PRECHARGE: if (i_addr[A_ALLBANK_BIT]) o_pre_all <= 1'b1;
               SDSQ_CMD_MODE_SET:  o_mode_ok <= 1'b1;
               SDSQ_CMD_REFRESH:   o_ref_cnt <= o_ref_cnt + 16'h0001;
               SDSQ_CMD_ACTIVATE, SDSQ_CMD_READ, SDSQ_CMD_WRITE: begin
                  o_acc_cnt <= o_acc_cnt + 16'h0001;
                  if (!(o_pre_all && o_mode_ok && o_ref_cnt >= 2)) o_err <= o_err + 8'h01;
               end
               default: ;
            endcase
         end
      end
      cke_q <= i_cke;
   end
endmodule

// ===== sdsq_divider.sv
// sdsq_divider: one-cycle enable pulse every 1 us for the long power-up wait
// assumes i_mclk at CLK_MHZ
`timescale 1ns/1ps
module sdsq_divider
   import sdsq_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_rst,
   output logic      o_tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } sdsq_div_t;
   sdsq_div_t st, next_st;
   localparam logic [7:0] DIV_LAST = 8'(CLK_MHZ - 1);
   // wrap counter
   always_comb begin
      next_st      = st;
      next_st.tick = (st.cnt == DIV_LAST);
      next_st.cnt  = (st.cnt == DIV_LAST) ? 8'h00 : st.cnt + 8'h01;
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst)
         st <= '0;
      else
         st <= next_st;
   end
   assign o_tick = st.tick;
endmodule

// ===== sdsq_pkg.sv
// sdsq_pkg: constants and types for the sdram init and self-refresh sequencer
// assumes a 200 MHz controller clock; the cycle counts except CLK_SETTLE_CYC are derived from it
package sdsq_pkg;
   localparam int CLK_MHZ        = 200;
   localparam int CLK_PERIOD_PS  = 5000;
   // power-up stable clock time
   localparam int T_POWERUP_US   = 200;
   localparam int POWERUP_CYC    = T_POWERUP_US * CLK_MHZ;
   // row cycle, refresh cycle, precharge, mode set, row active, setup (ps)
   localparam int T_RC_PS        = 55000;
   localparam int T_RFC_PS       = 55000;
   localparam int T_RP_PS        = 15000;
   localparam int T_MRD_PS       = 10000;
   localparam int T_RAS_PS       = 40000;
   localparam int T_IS_PS        = 1500;
   localparam int T_XSR_PS       = T_RC_PS + T_IS_PS;
   // least times round up to whole cycles
   localparam int RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RP_CYC  = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MRD_CYC = (T_MRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int XSR_CYC = (T_XSR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // clock must run this long after restart before the gate rises again
   localparam int CLK_SETTLE_CYC = 2;
   localparam int INIT_REFRESH_CNT  = 2;
   localparam int BURST_REFRESH_CNT = 8192;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // reset value of the mode word
   localparam logic [12:0] MODE_RESET = 13'h0_030;
   // all-banks bit on the address bus during precharge
   localparam int A_ALLBANK_BIT = 10;
   // command encoding {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      SDSQ_CMD_DESELECT  = 4'hF,
      no_operation_command = 4'h7,
      SDSQ_CMD_PRECHARGE = 4'h2,
      SDSQ_CMD_REFRESH   = 4'h1,
      SDSQ_CMD_MODE_SET  = 4'h0,
      SDSQ_CMD_ACTIVATE  = 4'h3,
      SDSQ_CMD_READ      = 4'h5,
      SDSQ_CMD_WRITE     = 4'h4
   } sdsq_cmd_t;
endpackage
